/* File: hw/fev_event_status.sv */
// Upper event status bits of the receive T1 framer, with per-channel
// signaling change registers, out-of-frame monitor and interrupt logic.
// Assumes one clock, synchronous framer inputs and an Avalon-MM master.
// Framer inputs are single-cycle pulses from the receive framer.
// Software polls or takes the level interrupt, then reads to clear.
//
// Operation
// RULE1 - Event flags hold until status read, then clear; all start at zero.
// RULE2 - Signaling flag bit 5 sets on any ABCD change in 24 channels.
// RULE3 - Per-channel signaling change bits kept in three separate registers.
// RULE4 - Alignment shift flag bit 4 sets when framing bits change position.
// RULE5 - Frame loss change flag bit 3 sets on declare and clear of OOF.
// RULE6 - OOF declared when threshold errors occur within configured window.
// RULE7 - Interrupt raised for a latched event only if its enable is set.
// RULE8 - Status bits 7 and 6 have no T1 function; they read zero.
// RULE9 - Event in same cycle as clearing read keeps its flag set.
`timescale 1ns/10ps
`include "fev_defs.svh"

module fev_event_status #(
  parameter int CHANNELS = 24,
  parameter int POS_W    = 8
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // Avalon-MM slave
  input  wire logic [13:0] ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  // Received signaling bits, one channel per pulse
  input  wire logic        SIG_VALID,
  input  wire logic [4:0]  SIG_CHAN,
  input  wire logic [3:0]  SIG_ABCD,
  // Framing bit checks, one per received framing bit
  input  wire logic        FBIT_VALID,
  input  wire logic        FBIT_ERR,
  // Framing search result: alignment found at position
  input  wire logic        ALIGN_VALID,
  input  wire logic [POS_W-1:0] ALIGN_POS,
  // Frame state and interrupt
  output logic             OUT_OF_FRAME,
  output logic             IRQ
);

  // Bus state
  logic                 req;
  logic                 accept;
  logic [11:0]          idx;
  logic                 wr_lane;
  logic [7:0]           rd_value;
  // Registers
  fev_pkg::fev_reg_t    status;
  fev_pkg::fev_reg_t    enable;
  fev_pkg::fev_reg_t    frm_cfg;
  logic [CHANNELS-1:0]  sig_chg;
  // Signaling memory
  logic [3:0]           sig_last [CHANNELS];
  logic [CHANNELS-1:0]  sig_seen;
  // Alignment and frame monitor
  logic [POS_W-1:0]     align_pos;
  logic                 align_known;
  fev_pkg::fev_sync_e   sync_state;
  logic [3:0]           win_cnt;
  logic [3:0]           err_cnt;
  // Event pulses and clear masks
  logic                 ev_sig;
  logic                 ev_alignment_shift_flag;
  logic                 ev_oof;
  logic [7:0]           next_status;
  logic [7:0]           status_clr;
  logic [CHANNELS-1:0]  next_sig_chg;
  logic [CHANNELS-1:0]  sig_hit;
  logic [CHANNELS-1:0]  sig_clr;
  logic [3:0]           thr;
  logic [3:0]           win;
  // Register selects and qualified strobes
  logic                 sel_status;
  logic                 sel_enable;
  logic                 sel_clear;
  logic                 sel_frm_cfg;
  logic                 sel_chg0;
  logic                 sel_chg1;
  logic                 sel_chg2;
  logic                 rd_take;
  logic                 rd_status;
  logic                 wr_enable;
  logic                 wr_frm_cfg;
  logic                 wr_clear;
  logic [7:0]           pending;

  // Bus decode
  assign req     = READ | WRITE;
  assign accept  = req & ~WAITREQUEST;
  assign idx     = ADDRESS[13:2];
  assign wr_lane = WRITE & accept & BYTEENABLE[0];
  assign thr     = frm_cfg[`FEV_CFG_THR_LSB +: 4];
  assign win     = frm_cfg[`FEV_CFG_WIN_LSB +: 4];

  // One select per mapped word
  assign sel_status  = (idx == `FEV_IDX_STATUS);
  assign sel_enable  = (idx == `FEV_IDX_ENABLE);
  assign sel_clear   = (idx == `FEV_IDX_CLEAR);
  assign sel_frm_cfg = (idx == `FEV_IDX_FRM_CFG);
  assign sel_chg0    = (idx == `FEV_IDX_SIGCHG0);
  assign sel_chg1    = (idx == `FEV_IDX_SIGCHG1);
  assign sel_chg2    = (idx == `FEV_IDX_SIGCHG2);

  // Strobes valid only on the accepting edge
  // Acting on the taken edge as well would apply a write twice
  assign rd_take    = READ & accept;
  assign rd_status  = rd_take & sel_status;
  assign wr_enable  = wr_lane & sel_enable;
  assign wr_frm_cfg = wr_lane & sel_frm_cfg;
  assign wr_clear   = wr_lane & sel_clear;

  // Read mux; unmapped and write-only locations read zero
  // Clear register is write-only, so it falls to the default
  // Reserved status bits masked here as well as in the flop
  always_comb begin
    rd_value = 8'h00;
    case (idx)
      `FEV_IDX_STATUS:  rd_value = status & `FEV_EVT_MASK;   // RULE8
      `FEV_IDX_ENABLE:  rd_value = enable;
      `FEV_IDX_FRM_CFG: rd_value = frm_cfg;
      `FEV_IDX_SIGCHG0: rd_value = sig_chg[7:0];
      `FEV_IDX_SIGCHG1: rd_value = sig_chg[15:8];
      `FEV_IDX_SIGCHG2: rd_value = sig_chg[23:16];
      default:          rd_value = 8'h00;
    endcase
  end

  // One wait cycle, then a single-cycle answer
  // The wait lets read data come from a flop, so the bus
  // never sees a combinational path from the address
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      WAITREQUEST <= 1'b1;
    end else if (req && WAITREQUEST) begin
      WAITREQUEST <= 1'b0;
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  // Read data captured as waitrequest falls
  // Loaded only on the taken edge so it stands through the answer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && WAITREQUEST) begin
      READDATA <= {24'h00_0000, rd_value};
    end
  end

  // Writable control registers
  // Enable keeps only the event bits; cfg takes the whole byte
  // Writes without the low byte lane are dropped
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      enable  <= `FEV_ENABLE_RESET;
      frm_cfg <= `FEV_CFG_RESET;
    end else begin
      if (wr_enable) begin
        enable <= WRITEDATA[7:0] & `FEV_EVT_MASK;
      end
      if (wr_frm_cfg) begin
        frm_cfg <= WRITEDATA[7:0];
      end
    end
  end

  // Signaling change detection, one compare per channel
  // First value after reset is only stored; it is not a change
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic hit;
      assign hit = SIG_VALID && (SIG_CHAN == 5'(ch));
      assign sig_hit[ch] = hit && sig_seen[ch] &&
                           (sig_last[ch] != SIG_ABCD);       // RULE2
      always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
          sig_last[ch] <= 4'h0;
          sig_seen[ch] <= 1'b0;
        end else if (hit) begin
          sig_last[ch] <= SIG_ABCD;
          sig_seen[ch] <= 1'b1;
        end
      end
    end
  endgenerate

  // Any channel change raises the common flag
  assign ev_sig = |sig_hit;

  // Channel change bits clear on read of their byte
  // Only returned bits clear, so a change after the capture survives
  always_comb begin
    sig_clr = '0;
    if (rd_take) begin
      if (sel_chg0) sig_clr[7:0]   = READDATA[7:0];
      if (sel_chg1) sig_clr[15:8]  = READDATA[7:0];
      if (sel_chg2) sig_clr[23:16] = READDATA[7:0];
    end
    next_sig_chg = (sig_chg & ~sig_clr) | sig_hit;           // RULE3 RULE9
  end

  // Per-channel change register
  // Same set-wins rule as the status flags
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sig_chg <= '0;
    end else begin
      sig_chg <= next_sig_chg;                               // RULE3
    end
  end

  // Alignment position memory and shift detection
  // First alignment after reset is only remembered
  // A repeat of the same position is not a shift
  assign ev_alignment_shift_flag = ALIGN_VALID && align_known &&
                   (ALIGN_POS != align_pos);                 // RULE4

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      align_pos   <= '0;
      align_known <= 1'b0;
    end else if (ALIGN_VALID) begin
      align_pos   <= ALIGN_POS;
      align_known <= 1'b1;
    end
  end

  // Framing error window counters
  // Idle while out of frame; window restarts every set count of bits
  // A threshold of zero never declares the defect
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      win_cnt <= 4'h0;
      err_cnt <= 4'h0;
    end else if (sync_state != fev_pkg::FEV_IN_FRAME) begin
      win_cnt <= 4'h0;
      err_cnt <= 4'h0;
    end else if (FBIT_VALID) begin
      if (win_cnt + 4'h1 >= win) begin
        win_cnt <= 4'h0;                                     // RULE6
        err_cnt <= 4'h0;
      end else begin
        win_cnt <= win_cnt + 4'h1;
        err_cnt <= err_cnt + {3'b000, FBIT_ERR};
      end
    end
  end

  // Frame alignment state; errors reaching threshold drop alignment
  // Alignment found while out of frame brings the framer back
  // Any illegal state falls back to out of frame
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync_state <= fev_pkg::FEV_OUT_OF_FRAME;
    end else begin
      case (sync_state)
        fev_pkg::FEV_IN_FRAME: begin
          if (FBIT_VALID && FBIT_ERR && (thr != 4'h0) &&
              (err_cnt + 4'h1 >= thr)) begin
            sync_state <= fev_pkg::FEV_OUT_OF_FRAME;         // RULE6
          end
        end
        fev_pkg::FEV_OUT_OF_FRAME: begin
          if (ALIGN_VALID) begin
            sync_state <= fev_pkg::FEV_IN_FRAME;
          end
        end
        default: sync_state <= fev_pkg::FEV_OUT_OF_FRAME;
      endcase
    end
  end

  // Declare or clear both count as a change
  // Output lags the state one edge; the flag rises with the output
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      OUT_OF_FRAME <= 1'b1;
    end else begin
      OUT_OF_FRAME <= (sync_state == fev_pkg::FEV_OUT_OF_FRAME);
    end
  end

  assign ev_oof = OUT_OF_FRAME !=
                  (sync_state == fev_pkg::FEV_OUT_OF_FRAME); // RULE5

  // Sticky status: read clears returned bits, clear register too
  // Clearing uses the word handed out, not the live flags, so a
  // flag set during the wait cycle survives for the next read
  always_comb begin
    status_clr = 8'h00;
    if (rd_status) begin
      status_clr = READDATA[7:0];                            // RULE1
    end
    if (wr_clear) begin
      status_clr = status_clr | WRITEDATA[7:0];
    end
    next_status = status & ~status_clr;
    next_status[`FEV_BIT_SIG]  = next_status[`FEV_BIT_SIG]  | ev_sig;
    next_status[`FEV_BIT_ALIGNMENT_SHIFT_FLAG] = next_status[`FEV_BIT_ALIGNMENT_SHIFT_FLAG] | ev_alignment_shift_flag;
    next_status[`FEV_BIT_OOF]  = next_status[`FEV_BIT_OOF]  | ev_oof;
  end

  // Status register; set wins over clear
  // Reserved bits forced low so they can never read back set
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      status <= `FEV_STATUS_RESET;                           // RULE1
    end else begin
      status <= next_status & `FEV_EVT_MASK;                 // RULE9 RULE8
    end
  end

  // Pending bits: a flag that is both latched and enabled
  genvar pb;
  generate
    for (pb = 0; pb < 8; pb++) begin : g_pend
      assign pending[pb] = next_status[pb] & enable[pb];     // RULE7
    end
  endgenerate

  // Level interrupt from enabled flags
  // Built from next status so the level rises with the flag
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |pending;                                       // RULE7
    end
  end

endmodule // fev_event_status

/* File: hw/fev_defs.svh */
// Register map, field positions and reset values of the framer event block.
// Included by the design; definitions only.
`ifndef FEV_DEFS_SVH
`define FEV_DEFS_SVH

// Register indices; byte address is four times the index
`define FEV_IDX_STATUS     12'hB04
`define FEV_IDX_ENABLE     12'hB05
`define FEV_IDX_CLEAR      12'hB06
`define FEV_IDX_FRM_CFG    12'h10B
`define FEV_IDX_SIGCHG0    12'h10D
`define FEV_IDX_SIGCHG1    12'h10E
`define FEV_IDX_SIGCHG2    12'h10F

// Event status bit positions
`define FEV_BIT_SIG        5
`define FEV_BIT_ALIGNMENT_SHIFT_FLAG       4
`define FEV_BIT_OOF        3
`define FEV_EVT_MASK       8'h38

// Framing configuration fields: threshold [7:4], window [3:0]
`define FEV_CFG_THR_LSB    4
`define FEV_CFG_WIN_LSB    0
`define FEV_CFG_RESET      8'h24

// Reset values
`define FEV_STATUS_RESET   8'h00
`define FEV_ENABLE_RESET   8'h00

`endif

/* File: hw/fev_pkg.sv */
// Types shared by the framer event block.
// Needs nothing from its surroundings.
package fev_pkg;

  // Frame alignment state of the receive framer
  typedef enum logic [0:0] {
    FEV_IN_FRAME,
    FEV_OUT_OF_FRAME
  } fev_sync_e;

  typedef logic [7:0] fev_reg_t;

endpackage

/* File: testbench/fev_event_status_sva.sv */
// Checker for the framer event block, watching top-level ports only.
// Bound from the bench top file; one clock, synchronous reset.
`timescale 1ns/10ps
`include "fev_defs.svh"

module fev_event_status_sva (
  // Clock, reset and bus
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic [13:0] ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  // Events and outputs
  input wire logic        SIG_VALID,
  input wire logic        FBIT_VALID,
  input wire logic        FBIT_ERR,
  input wire logic        ALIGN_VALID,
  input wire logic        OUT_OF_FRAME,
  input wire logic        IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  // Request taken, then a single answer cycle
  sequence s_taken;
    (READ || WRITE) && WAITREQUEST;
  endsequence
  sequence s_answer;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence

  property p_bus_answer;
    s_taken |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_rst_out;
    disable iff (1'b0) SYS_RST |=> WAITREQUEST && !IRQ && OUT_OF_FRAME;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong");
  property p_high_zero;
    READDATA[31:8] == 24'h000000;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("upper data set");
  property p_reserved;
    READ && !WAITREQUEST && ADDRESS[13:2] == `FEV_IDX_STATUS
      |-> (READDATA[7:0] & 8'hC7) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set");
  property p_irq_hold;
    IRQ && !READ && !WRITE |=> IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_irq_cause;
    $rose(IRQ) |-> $past(SIG_VALID || ALIGN_VALID || WRITE) ||
      $past(FBIT_VALID || ALIGN_VALID || WRITE, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
  property p_oof_clear;
    OUT_OF_FRAME && ALIGN_VALID |-> ##2 !OUT_OF_FRAME;
  endproperty
  a_oof_clear: assert property (p_oof_clear) else $error("oof kept");
  property p_oof_cause;
    $rose(OUT_OF_FRAME) |-> $past(FBIT_VALID && FBIT_ERR, 2);
  endproperty
  a_oof_cause: assert property (p_oof_cause) else $error("oof no cause");
endmodule // fev_event_status_sva

/* File: testbench/fev_event_status_bench.sv */
// Self-checking bench for the framer event block.
// Drives the Avalon port and the framer event inputs directly.
`timescale 1ns/10ps
`include "fev_defs.svh"

module fev_event_status_bench;
  logic        REF_CLK, SYS_RST, READ, WRITE, WAITREQUEST, IRQ;
  logic        SIG_VALID, FBIT_VALID, FBIT_ERR, ALIGN_VALID, OUT_OF_FRAME;
  logic [13:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA;
  logic [3:0]  BYTEENABLE, SIG_ABCD;
  logic [4:0]  SIG_CHAN;
  logic [7:0]  ALIGN_POS;
  int          fails, tests_run;

  fev_event_status dut (.*);

  // Clock at 125 MHz
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge REF_CLK);
    ADDRESS <= {i, 2'b00};
    WRITEDATA <= {24'h000000, d};
    READ <= ~w;
    WRITE <= w;
    do @(posedge REF_CLK); while (WAITREQUEST !== 1'b0);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, q);
    chk($sformatf("reg %h", i), {24'h000000, e}, q);
  endtask

  // Event pulse: 0 signaling on channel 3, 1 framing bit, 2 alignment
  task automatic ev(input int k, input logic [7:0] v);
    @(posedge REF_CLK);
    SIG_ABCD <= v[3:0];
    FBIT_ERR <= v[0];
    ALIGN_POS <= v;
    SIG_VALID <= (k == 0);
    FBIT_VALID <= (k == 1);
    ALIGN_VALID <= (k == 2);
    @(posedge REF_CLK);
    {SIG_VALID, FBIT_VALID, ALIGN_VALID} <= 3'b000;
    @(posedge REF_CLK);
    #1;
  endtask

  // Main sequence
  initial begin
    {READ, WRITE, SIG_VALID, FBIT_VALID, FBIT_ERR, ALIGN_VALID} = 6'h00;
    {ADDRESS, WRITEDATA, SIG_ABCD, ALIGN_POS} = 58'h0;
    BYTEENABLE = 4'hF;
    SIG_CHAN = 5'h03;
    SYS_RST = 1'b1;
    repeat (16) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    rd(`FEV_IDX_STATUS, 8'h00);
    rd(`FEV_IDX_FRM_CFG, 8'h24);
    wr(`FEV_IDX_ENABLE, 8'h38);
    rd(`FEV_IDX_ENABLE, 8'h38);
    ev(0, 8'h05);
    ev(0, 8'h05);
    rd(`FEV_IDX_STATUS, 8'h00);
    ev(0, 8'h06);
    chk("irq", 1, IRQ);
    rd(`FEV_IDX_SIGCHG0, 8'h08);
    rd(`FEV_IDX_STATUS, 8'h20);
    rd(`FEV_IDX_STATUS, 8'h00);
    chk("irq", 0, IRQ);
    ev(2, 8'h09);
    chk("oof", 0, OUT_OF_FRAME);
    ev(2, 8'h09);
    rd(`FEV_IDX_STATUS, 8'h08);
    ev(2, 8'h0C);
    rd(`FEV_IDX_STATUS, 8'h10);
    ev(1, 8'h01);
    ev(1, 8'h00);
    chk("oof", 0, OUT_OF_FRAME);
    ev(1, 8'h01);
    chk("oof", 1, OUT_OF_FRAME);
    rd(`FEV_IDX_STATUS, 8'h08);
    wr(`FEV_IDX_ENABLE, 8'h00);
    ev(0, 8'h09);
    chk("irq", 0, IRQ);
    wr(`FEV_IDX_ENABLE, 8'h20);
    repeat (2) @(posedge REF_CLK);
    chk("irq", 1, IRQ);
    wr(`FEV_IDX_CLEAR, 8'h20);
    rd(`FEV_IDX_STATUS, 8'h00);
    rd(12'h001, 8'h00);
    test_done;
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge REF_CLK);
    fails++;
    test_done;
  end
endmodule // fev_event_status_bench

bind fev_event_status fev_event_status_sva u_sva (.*);
